//--- hdl/dsk_ctrl.sv
// Disk controller command, abort, status and track-write encoder.
// Assumes an APB master, synchronous drive inputs and an engine giving done/byte ticks.
`timescale 1ns/10ps
`include "dsk_map.svh"
module dsk_ctrl
	import dsk_pkg::*;
(
	input  wire logic        clk_in,              // 100 MHz clock
	input  wire logic        rst_n_in,            // Synchronous reset, active low
	input  wire logic        ce_in,               // Clock enable, freezes state when low
	input  wire logic        psel_in,             // APB select
	input  wire logic        penable_in,          // APB enable
	input  wire logic        pwrite_in,           // APB direction
	input  wire logic [7:0]  paddr_in,            // APB byte address
	input  wire logic [31:0] pwdata_in,           // APB write data
	output logic      [31:0] prdata_out,          // APB read data
	output logic             pready_out,          // APB ready
	output logic             pslverr_out,         // APB error, unmapped address
	input  wire logic        ready_in,            // Drive ready
	input  wire logic        chip_clear_in,       // Chip clear, active high
	input  wire logic        protect_sense_in,    // Track write inhibit, low blocks
	input  wire logic        protect_tab_in,      // Protect tab, low when protected
	input  wire logic        head_settle_in,      // Head settled
	input  wire logic        track_zero_in,       // Track zero, low at track 0
	input  wire logic        index_pulse_in,      // Index, low during pulse
	input  wire logic        done_in,             // Engine: command finished
	input  wire logic        seek_err_in,         // Engine: verify failed, with done
	input  wire logic        crc_err_in,          // Engine: CRC error, with done
	input  wire logic        rnf_in,              // Engine: record not found, with done
	input  wire logic        wfault_in,           // Engine: write fault, with done
	input  wire logic [1:0]  rec_type_in,         // Engine: record type, with done
	input  wire logic        byte_tick_in,        // One pulse per disk byte time
	input  wire logic [7:0]  rd_byte_in,          // Byte read from disk, with tick
	output logic             irq_out,             // Interrupt request
	output logic             byte_xfer_request_out, // Byte transfer request
	output logic             head_load_out,       // Head load
	output logic [7:0]       wr_data_out,         // Byte to write to disk
	output logic [7:0]       wr_clock_out,        // Clock pattern for that byte
	output logic             wr_strobe_out        // One-cycle pulse: byte valid
);
	// ==========================================================
	// State
	dsk_state_e  state_q, state_d;
	dsk_type_e   type_q, type_d;
	logic        busy_q, busy_d;
	logic        irq_q, irq_d;
	logic        imm_q, imm_d;
	logic [2:0]  cond_q, cond_d;
	logic        drq_q, drq_d;
	logic [7:0]  hold_q, hold_d;
	logic        lost_q, lost_d;
	logic        err4_q, err4_d;
	logic        err3_q, err3_d;
	logic        b6_q, b6_d;
	logic        b5_q, b5_d;
	logic        head_q, head_d;
	logic [15:0] crc_q, crc_d;
	logic        crc_lo_q, crc_lo_d;
	logic [7:0]  wdat_q, wdat_d;
	logic [7:0]  wclk_q, wclk_d;
	logic        wstb_q, wstb_d;
	logic        rdy_prev_q;
	logic        idx_prev_q;
	logic [31:0] prdata_q, prdata_d;

	// ==========================================================
	// Bus decode
	wire logic       setup_w    = psel_in & ~penable_in;
	wire logic       access_w   = psel_in & penable_in;
	wire logic       hit_cmd    = paddr_in == `DSK_OFF_CMD;
	wire logic       hit_data   = paddr_in == `DSK_OFF_DATA;
	wire logic       cmd_wr     = access_w & pwrite_in & hit_cmd;
	wire logic       stat_rd    = access_w & ~pwrite_in & hit_cmd;
	wire logic       data_wr    = access_w & pwrite_in & hit_data;
	wire logic       data_rd    = access_w & ~pwrite_in & hit_data;
	wire logic [7:0] cmd_byte   = pwdata_in[7:0];
	wire logic [3:0] op         = cmd_byte[7:4];
	wire logic       abort_wr   = cmd_wr & (op == `DSK_OP_ABORT);
	wire logic       other_wr   = cmd_wr & (op != `DSK_OP_ABORT);
	wire logic       rdy_rise   = ready_in & ~rdy_prev_q;
	wire logic       rdy_fall   = ~ready_in & rdy_prev_q;
	wire logic       idx_edge   = ~index_pulse_in & idx_prev_q;
	wire logic       is_read    = (type_q == DSK_T_RD_SEC) | (type_q == DSK_T_RD_ADDR)
	                              | (type_q == DSK_T_RD_TRK);
	wire logic       is_wsec    = type_q == DSK_T_WR_SEC;
	wire logic       fire_cond  = (cond_q[0] & rdy_rise) | (cond_q[1] & rdy_fall)
	                              | (cond_q[2] & idx_edge);
	wire logic       is_mark    = ((hold_q >= `DSK_PAT_DAM_LO) & (hold_q <= `DSK_PAT_DAM_HI))
	                              | (hold_q == `DSK_PAT_IDAM);
	wire logic       crc_reset  = (hold_q >= `DSK_PAT_DAM_LO) & (hold_q <= `DSK_PAT_IDAM);

	// Command type from the opcode nibble
	dsk_type_e new_type;
	always_comb
	begin
		unique case (op)
			`DSK_OP_RD_SEC0, `DSK_OP_RD_SEC1: new_type = DSK_T_RD_SEC;
			`DSK_OP_WR_SEC0, `DSK_OP_WR_SEC1: new_type = DSK_T_WR_SEC;
			`DSK_OP_RD_ADDR:                  new_type = DSK_T_RD_ADDR;
			`DSK_OP_RD_TRK:                   new_type = DSK_T_RD_TRK;
			`DSK_OP_WR_TRK:                   new_type = DSK_T_WR_TRK;
			default:                          new_type = DSK_T_POS;
		endcase
	end

	// ==========================================================
	// Status register
	logic [7:0] status_w;
	wire logic  s7_w = ~ready_in | chip_clear_in;
	always_comb
	begin
		unique case (type_q)
			DSK_T_POS:     status_w = {s7_w, ~protect_tab_in, head_q & head_settle_in,
			                           err4_q, err3_q, ~track_zero_in, ~index_pulse_in,
			                           busy_q};
			DSK_T_RD_ADDR: status_w = {s7_w, 2'b00, err4_q, err3_q, lost_q, drq_q, busy_q};
			DSK_T_RD_TRK:  status_w = {s7_w, 4'b0000, lost_q, drq_q, busy_q};
			DSK_T_WR_TRK:  status_w = {s7_w, b6_q, b5_q, 2'b00, lost_q, drq_q, busy_q};
			default:       status_w = {s7_w, b6_q, b5_q, err4_q, err3_q, lost_q, drq_q,
			                           busy_q};
		endcase
	end

	// CRC-CCITT over one byte, most significant bit first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
			r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? `DSK_CRC_POLY : 16'h0000);
		return r;
	endfunction

	// ==========================================================
	// Next state
	always_comb
	begin
		state_d  = state_q;
		type_d   = type_q;
		busy_d   = busy_q;
		imm_d    = imm_q;
		cond_d   = cond_q;
		drq_d    = drq_q;
		hold_d   = hold_q;
		lost_d   = lost_q;
		err4_d   = err4_q;
		err3_d   = err3_q;
		b6_d     = b6_q;
		b5_d     = b5_q;
		head_d   = head_q;
		crc_d    = crc_q;
		crc_lo_d = crc_lo_q;
		wdat_d   = wdat_q;
		wclk_d   = wclk_q;
		wstb_d   = 1'b0;
		prdata_d = prdata_q;
		// Reading status or writing a command acknowledges a pending interrupt; a set wins below
		irq_d    = irq_q & ~stat_rd & ~cmd_wr;
		if (setup_w && !pwrite_in)
			prdata_d = hit_cmd ? {24'h00_0000, status_w} : (hit_data ? {24'h00_0000, hold_q}
			           : 32'h0000_0000);
		if (data_wr)
		begin
			hold_d = pwdata_in[7:0];
			if (!is_read)
				drq_d = 1'b0;
		end
		if (data_rd && is_read)
			drq_d = 1'b0;
		if (fire_cond)
			irq_d = 1'b1;
		// Byte time handling for transfers
		if (byte_tick_in && busy_q && state_q == DSK_BUSY && is_read)
		begin
			hold_d = rd_byte_in;
			drq_d  = 1'b1;
			if (drq_q)
				lost_d = 1'b1;
		end
		if (byte_tick_in && ((busy_q && state_q == DSK_BUSY && is_wsec)
		    || state_q == DSK_TRK_RUN))
		begin
			wstb_d = 1'b1;
			wclk_d = `DSK_CLK_NORM;
			drq_d  = 1'b1;
			if (crc_lo_q)
			begin
				wdat_d   = crc_q[7:0];
				crc_lo_d = 1'b0;
				drq_d    = drq_q;
			end
			else if (drq_q)
			begin
				wdat_d = 8'h00;
				lost_d = 1'b1;
				crc_d  = crc_byte(crc_q, 8'h00);
			end
			else if (state_q == DSK_TRK_RUN && hold_q == `DSK_PAT_CRC)
			begin
				wdat_d   = crc_q[15:8];
				crc_lo_d = 1'b1;
				// F7 is consumed here, so the request raised above stays up for the next byte
			end
			else
			begin
				wdat_d = hold_q;
				crc_d  = crc_byte(crc_q, hold_q);
				if (state_q == DSK_TRK_RUN)
				begin
					if (crc_reset)
						crc_d = crc_byte(`DSK_CRC_INIT, hold_q);
					if (is_mark)
						wclk_d = `DSK_CLK_MARK;
					else if (hold_q == `DSK_PAT_INDEX)
						wclk_d = `DSK_CLK_INDEX;
					// Spare FD falls through with the normal clock
				end
			end
		end
		// Sequencing
		unique case (state_q)
			DSK_IDLE: ;
			DSK_BUSY:
				if (done_in)
				begin
					busy_d  = 1'b0;
					state_d = DSK_IDLE;
					irq_d   = 1'b1;
					err4_d  = (type_q == DSK_T_POS) ? seek_err_in : rnf_in;
					err3_d  = crc_err_in;
					b6_d    = (type_q == DSK_T_RD_SEC) ? rec_type_in[1] : b6_q;
					b5_d    = (type_q == DSK_T_RD_SEC) ? rec_type_in[0] : wfault_in;
					drq_d   = 1'b0;
				end
			DSK_TRK_WAIT:
				if (idx_edge)
				begin
					if (drq_q)
					begin
						lost_d  = 1'b1;
						busy_d  = 1'b0;
						state_d = DSK_IDLE;
						irq_d   = 1'b1;
						drq_d   = 1'b0;
					end
					else
					begin
						state_d = DSK_TRK_RUN;
						crc_d   = `DSK_CRC_INIT;
					end
				end
			DSK_TRK_RUN:
				if (idx_edge)
				begin
					busy_d  = 1'b0;
					state_d = DSK_IDLE;
					irq_d   = 1'b1;
					drq_d   = 1'b0;
				end
		endcase
		// Commands after sequencing, so they take priority over engine events; chip clear wins over both
		if (abort_wr)
		begin
			state_d  = DSK_IDLE;
			busy_d   = 1'b0;
			cond_d   = cmd_byte[2:0];
			imm_d    = cmd_byte[3];
			crc_lo_d = 1'b0;
			if (!busy_q)
			begin
				type_d = DSK_T_POS;
				err4_d = 1'b0;
				err3_d = 1'b0;
				drq_d  = 1'b0;
				lost_d = 1'b0;
			end
		end
		else if (other_wr)
		begin
			type_d   = new_type;
			cond_d   = 3'b000;
			err4_d   = 1'b0;
			err3_d   = 1'b0;
			b6_d     = 1'b0;
			b5_d     = 1'b0;
			lost_d   = 1'b0;
			drq_d    = 1'b0;
			crc_lo_d = 1'b0;
			head_d   = 1'b1;
			busy_d   = 1'b1;
			state_d  = DSK_BUSY;
			if (new_type != DSK_T_POS && !ready_in)
			begin
				busy_d  = 1'b0;
				state_d = DSK_IDLE;
				irq_d   = 1'b1;
			end
			else if (new_type == DSK_T_WR_TRK && !protect_sense_in)
			begin
				busy_d  = 1'b0;
				state_d = DSK_IDLE;
				b6_d    = 1'b1;
				irq_d   = 1'b1;
			end
			else if (new_type == DSK_T_WR_TRK)
			begin
				state_d = DSK_TRK_WAIT;
				drq_d   = 1'b1;
			end
			else if (new_type == DSK_T_WR_SEC)
				drq_d = 1'b1;
		end
		if (chip_clear_in)
		begin
			busy_d  = 1'b0;
			state_d = DSK_IDLE;
			head_d  = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			state_q <= DSK_IDLE;
			type_q  <= DSK_T_POS;
			{busy_q, irq_q, imm_q, drq_q, lost_q, err4_q, err3_q} <= 7'b000_0000;
			{b6_q, b5_q, head_q, crc_lo_q, wstb_q} <= 5'b0_0000;
			{rdy_prev_q, idx_prev_q} <= {ready_in, index_pulse_in};
			cond_q   <= 3'b000;
			hold_q   <= 8'h00;
			crc_q    <= `DSK_CRC_INIT;
			wdat_q   <= 8'h00;
			wclk_q   <= `DSK_CLK_NORM;
			prdata_q <= 32'h0000_0000;
		end
		else if (ce_in)
		begin
			state_q <= state_d;
			type_q  <= type_d;
			{busy_q, irq_q, imm_q, drq_q, lost_q, err4_q, err3_q} <=
				{busy_d, irq_d, imm_d, drq_d, lost_d, err4_d, err3_d};
			{b6_q, b5_q, head_q, crc_lo_q, wstb_q} <= {b6_d, b5_d, head_d, crc_lo_d, wstb_d};
			{rdy_prev_q, idx_prev_q} <= {ready_in, index_pulse_in};
			cond_q   <= cond_d;
			hold_q   <= hold_d;
			crc_q    <= crc_d;
			wdat_q   <= wdat_d;
			wclk_q   <= wclk_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata_out            = prdata_q;
	assign pready_out            = 1'b1;
	assign pslverr_out           = access_w & ~hit_cmd & ~hit_data;
	assign irq_out               = irq_q | imm_q;
	assign byte_xfer_request_out = drq_q;
	assign head_load_out         = head_q;
	assign wr_data_out           = wdat_q;
	assign wr_clock_out          = wclk_q;
	assign wr_strobe_out         = wstb_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	chk_mark_clock: assert property (wr_strobe_out && wr_clock_out == `DSK_CLK_MARK |->
		(wr_data_out >= `DSK_PAT_DAM_LO && wr_data_out <= `DSK_PAT_DAM_HI)
		|| wr_data_out == `DSK_PAT_IDAM) else $error("mark clock on non-mark byte");
	chk_crc_pair: assert property (ce_in && state_q == DSK_TRK_RUN && byte_tick_in &&
		!crc_lo_q && !drq_q && hold_q == `DSK_PAT_CRC && !abort_wr && !chip_clear_in |=>
		wr_strobe_out && wr_clock_out == `DSK_CLK_NORM && wr_data_out == $past(crc_q[15:8])
		&& crc_lo_q) else $error("F7 did not start a CRC pair");
	chk_protect_block: assert property (ce_in && other_wr && new_type == DSK_T_WR_TRK &&
		ready_in && !protect_sense_in && !chip_clear_in |=> irq_out && status_w[6] && !busy_q
		&& state_q == DSK_IDLE) else $error("protected track write not blocked");
	chk_index_irq: assert property (ce_in && cond_q[2] && idx_edge && !cmd_wr |=> irq_out)
		else $error("index condition gave no interrupt");
	chk_imm_hold: assert property (imm_q && !(ce_in && abort_wr) |=> imm_q && irq_out)
		else $error("immediate interrupt dropped");
	chk_abort_zero: assert property (ce_in && abort_wr && cmd_byte[3:0] == 4'h0 |=>
		!busy_q && !imm_q && state_q == DSK_IDLE) else $error("plain abort left busy");
	chk_abort_keep: assert property (ce_in && abort_wr && busy_q |=>
		type_q == $past(type_q) && err4_q == $past(err4_q) && lost_q == $past(lost_q))
		else $error("abort during command changed status");
	chk_cmd_busy: assert property (ce_in && other_wr && ready_in && protect_sense_in
		&& !chip_clear_in |=> busy_q) else $error("command did not set busy");
	chk_not_ready: assert property (ce_in && setup_w && !pwrite_in && hit_cmd |=>
		prdata_out[7] == $past(!ready_in || chip_clear_in)) else $error("bit 7 wrong");
	chk_trk_request: assert property (ce_in && other_wr && new_type == DSK_T_WR_TRK &&
		ready_in && protect_sense_in && !chip_clear_in |=> byte_xfer_request_out)
		else $error("track write gave no request");

	cov_trk_crc: cover property (state_q == DSK_TRK_RUN && crc_lo_q ##1 wr_strobe_out);
	cov_abort_busy: cover property (busy_q && abort_wr);
	cov_lost: cover property ($rose(lost_q));
	cov_ready_irq: cover property (cond_q[0] && rdy_rise ##1 irq_out);
endmodule // dsk_ctrl

//--- hdl/dsk_map.svh
// Constants for the disk controller status and abort block.
// Assumes a 32-bit APB master and a media engine that reports sequencing events.
`ifndef DSK_MAP_SVH
`define DSK_MAP_SVH
// ==========================================================
// Register offsets
`define DSK_OFF_CMD     8'h00
`define DSK_OFF_DATA    8'h04
// ==========================================================
// Command opcodes (upper nibble)
`define DSK_OP_RD_SEC0  4'h8
`define DSK_OP_RD_SEC1  4'h9
`define DSK_OP_WR_SEC0  4'hA
`define DSK_OP_WR_SEC1  4'hB
`define DSK_OP_RD_ADDR  4'hC
`define DSK_OP_ABORT    4'hD
`define DSK_OP_RD_TRK   4'hE
`define DSK_OP_WR_TRK   4'hF
// ==========================================================
// Track write patterns and clock marks
`define DSK_PAT_CRC     8'hF7
`define DSK_PAT_DAM_LO  8'hF8
`define DSK_PAT_DAM_HI  8'hFB
`define DSK_PAT_INDEX   8'hFC
`define DSK_PAT_SPARE   8'hFD
`define DSK_PAT_IDAM    8'hFE
`define DSK_CLK_NORM    8'hFF
`define DSK_CLK_MARK    8'hC7
`define DSK_CLK_INDEX   8'hD7
`define DSK_CRC_INIT    16'hFFFF
`define DSK_CRC_POLY    16'h1021
`endif

//--- hdl/dsk_pkg.sv
// Types for the disk controller status and abort block.
// Assumes dsk_map.svh supplies the numeric constants.
package dsk_pkg;
	typedef enum logic [3:0] {
		DSK_IDLE     = 4'b0001,
		DSK_BUSY     = 4'b0010,
		DSK_TRK_WAIT = 4'b0100,
		DSK_TRK_RUN  = 4'b1000
	} dsk_state_e;
	typedef enum logic [2:0] {
		DSK_T_POS, DSK_T_RD_ADDR, DSK_T_RD_SEC, DSK_T_RD_TRK, DSK_T_WR_SEC, DSK_T_WR_TRK
	} dsk_type_e;
endpackage

//--- verification/dsk_drive_model.sv
// Drive-side model: ready level, media sense pins, byte-time ticks and index pulses.
// Assumes one bench process calls its tasks; every change lands just after a rising edge.
`timescale 1ns/10ps
module dsk_drive_model (
	input  wire logic       clk_in,      // Bench clock
	output logic            ready_out,   // Drive ready
	output logic            tab_out,     // Protect tab, low when protected
	output logic            sense_out,   // Track write inhibit, low blocks
	output logic            index_out,   // Index, low during pulse
	output logic            tick_out,    // One pulse per byte time
	output logic [7:0]      rd_byte_out  // Byte from disk, valid with tick
);
	// ==========================================================
	// Levels
	initial
	begin
		ready_out   = 1'b1;
		tab_out     = 1'b1;
		sense_out   = 1'b1;
		index_out   = 1'b1;
		tick_out    = 1'b0;
		rd_byte_out = 8'h5A;
	end
	task automatic set_lvl(input logic rdy, input logic sns);
		@(posedge clk_in);
		ready_out <= rdy;
		sense_out <= sns;
	endtask
	// ==========================================================
	// Byte time: outside the tick the read line shows the inverse, never a stale byte
	task automatic tick(input logic [7:0] b);
		@(posedge clk_in);
		tick_out    <= 1'b1;
		rd_byte_out <= b;
		@(posedge clk_in);
		tick_out    <= 1'b0;
		rd_byte_out <= ~b;
		repeat (2) @(posedge clk_in);
	endtask
	task automatic index_pulse();
		@(posedge clk_in);
		index_out <= 1'b0;
		repeat (2) @(posedge clk_in);
		index_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask
endmodule // dsk_drive_model

//--- verification/testbench.sv
// Self-checking bench: APB host tasks, drive model, queued read and write-stream notes.
// Assumes dsk_ctrl answers APB with no wait states and a drive model beside it.
`timescale 1ns/10ps
`include "dsk_map.svh"
`define CHK(nm, e, g) \
	begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
	// ==========================================================
	// Signals
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, r, b;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        done = 1'b0, seek_err = 1'b0, crc_err = 1'b0, rnf = 1'b0, tz = 1'b1;
	logic [1:0]  rec = 2'b00;
	logic        ce = 1'b1, clr = 1'b0;
	logic [15:0] crc;
	logic [15:0] rq[$];
	logic [15:0] sq[$];
	logic [7:0]  pats [9] = '{8'hFE, 8'h00, 8'hF7, 8'hFC, 8'hFD, 8'hF8, 8'hF9, 8'hFA, 8'hFB};
	integer      seed = 32'h7c75_40c9;
	int          miscompares = 0, checked = 0;
	wire [31:0]  prdata;
	wire [7:0]   wdat, wclk, rdb;
	wire         pready, pslverr, irq, byte_xfer_request, hl, strobe, rdy, tab, sense, idx, tick;
	always #5 clk = ~clk;
	dsk_ctrl u_dut (.clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .ready_in(rdy),
		.chip_clear_in(clr), .protect_sense_in(sense), .protect_tab_in(tab),
		.head_settle_in(1'b1), .track_zero_in(tz), .index_pulse_in(idx), .done_in(done),
		.seek_err_in(seek_err), .crc_err_in(crc_err), .rnf_in(rnf), .wfault_in(1'b0),
		.rec_type_in(rec), .byte_tick_in(tick), .rd_byte_in(rdb), .irq_out(irq),
		.byte_xfer_request_out(byte_xfer_request), .head_load_out(hl), .wr_data_out(wdat),
		.wr_clock_out(wclk), .wr_strobe_out(strobe));
	dsk_drive_model u_drv (.clk_in(clk), .ready_out(rdy), .tab_out(tab), .sense_out(sense),
		.index_out(idx), .tick_out(tick), .rd_byte_out(rdb));
	// ==========================================================
	// Result watcher: oldest note against each read and each written byte
	always @(posedge clk)
	begin
		if (psel && penable && pready && !pwrite && rq.size() > 0)
		begin
			`CHK("status", rq[0][7:0], prdata[7:0] & rq[0][15:8])
			void'(rq.pop_front());
		end
		if (strobe === 1'b1)
		begin
			`CHK("track byte", (sq.size() > 0) ? sq[0] : 16'hxxxx, {wdat, wclk})
			if (sq.size() > 0)
				void'(sq.pop_front());
		end
	end
	// ==========================================================
	// Host tasks; for reads d is the expected value under mask m
	task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] d,
		input logic [7:0] m);
		int n;
		@(posedge clk);
		psel   <= 1'b1;
		paddr  <= a;
		pwrite <= wr;
		pwdata <= {24'h00_0000, d};
		if (!wr)
			rq.push_back({m, d & m});
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		for (n = 0; pready !== 1'b1 && n < 50; n++)
			@(posedge clk);
		if (n == 50)
			miscompares++;
		`CHK("pslverr", (a > 8'h04), pslverr)
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] c);
		apb(8'h00, 1'b1, c, 8'h00);
		settle(2);
	endtask
	task automatic fin(input logic s, input logic c, input logic f, input logic [1:0] t);
		@(posedge clk);
		done     <= 1'b1;
		seek_err <= s;
		crc_err  <= c;
		rnf      <= f;
		rec      <= t;
		@(posedge clk);
		done <= 1'b0;
		settle(2);
	endtask
	function automatic logic [7:0] pos(input logic h, input logic bz);
		return {~rdy, ~tab, h, 2'b00, ~tz, ~idx, bz};
	endfunction
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `DSK_CRC_POLY : 16'h0000);
		return c;
	endfunction
	function automatic logic [7:0] clk_of(input logic [7:0] d);
		if (d == `DSK_PAT_INDEX)
			return `DSK_CLK_INDEX;
		if (d == `DSK_PAT_IDAM || (d >= `DSK_PAT_DAM_LO && d <= `DSK_PAT_DAM_HI))
			return `DSK_CLK_MARK;
		return `DSK_CLK_NORM;
	endfunction
	task automatic end_sim();
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#100000;
		miscompares++;
		end_sim();
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		r = 8'($random(seed));
		tz = r[0];
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		stat_chk: stat_dummy();
	end
	task automatic stat_dummy();
		apb(8'h00, 1'b0, pos(1'b0, 1'b0), 8'hFF);
		apb(8'h08, 1'b0, 8'h00, 8'hFF);
		cmd(8'h00);
		`CHK("head load", 1'b1, hl)
		apb(8'h00, 1'b0, pos(1'b1, 1'b1), 8'hFF);
		fin(1'b1, 1'b1, 1'b0, 2'b00);
		`CHK("irq done", 1'b1, irq)
		apb(8'h00, 1'b0, pos(1'b1, 1'b0) | 8'h18, 8'hFF);
		cmd(8'hD0);
		`CHK("irq none", 1'b0, irq)
		apb(8'h00, 1'b0, pos(1'b1, 1'b0), 8'hFF);
		cmd(8'hD8);
		`CHK("irq immediate", 1'b1, irq)
		apb(8'h00, 1'b0, pos(1'b1, 1'b0), 8'hFF);
		cmd(8'h00);
		`CHK("irq held", 1'b1, irq)
		cmd(8'hD0);
		`CHK("irq cleared", 1'b0, irq)
		cmd(8'h80);
		fin(1'b0, 1'b1, 1'b1, 2'b11);
		apb(8'h00, 1'b0, 8'h78, 8'hFF);
		cmd(8'h80);
		apb(8'h00, 1'b0, 8'h01, 8'hFF);
		r = 8'($random(seed));
		u_drv.tick(~r);
		u_drv.tick(r);
		apb(8'h00, 1'b0, 8'h07, 8'hFF);
		cmd(8'hD0);
		apb(8'h00, 1'b0, 8'h06, 8'hFF);
		apb(8'h04, 1'b0, r, 8'hFF);
		settle(2);
		`CHK("drq after read", 1'b0, byte_xfer_request)
		u_drv.set_lvl(1'b0, 1'b1);
		cmd(8'h80);
		`CHK("irq refused", 1'b1, irq)
		apb(8'h00, 1'b0, 8'h80, 8'h81);
		for (int i = 0; i < 3; i++)
		begin
			cmd(8'h00);
			cmd(8'hD0 | (8'h01 << i));
			`CHK("irq armed", 1'b0, irq)
			if (i == 2)
				u_drv.index_pulse();
			else
				u_drv.set_lvl(i == 0, 1'b1);
			settle(4);
			`CHK("irq condition", 1'b1, irq)
		end
		cmd(8'hD0);
		u_drv.set_lvl(1'b1, 1'b0);
		cmd(8'hF0);
		`CHK("irq protect", 1'b1, irq)
		apb(8'h00, 1'b0, 8'h40, 8'h41);
		u_drv.set_lvl(1'b1, 1'b1);
		cmd(8'hF0);
		`CHK("drq at once", 1'b1, byte_xfer_request)
		apb(8'h04, 1'b1, 8'hFE, 8'h00);
		u_drv.index_pulse();
		r = 8'($random(seed)) & 8'h7F;
		crc = crc_step(crc_step(16'hFFFF, 8'hFE), r);
		foreach (pats[i])
		begin
			b = (i == 1) ? r : pats[i];
			if (i > 0)
				apb(8'h04, 1'b1, b, 8'h00);
			if (b == `DSK_PAT_CRC)
			begin
				sq.push_back({crc[15:8], `DSK_CLK_NORM});
				sq.push_back({crc[7:0], `DSK_CLK_NORM});
				u_drv.tick(8'h00);
			end
			else
				sq.push_back({b, clk_of(b)});
			u_drv.tick(8'h00);
		end
		sq.push_back({8'h00, `DSK_CLK_NORM});
		u_drv.tick(8'h00);
		u_drv.index_pulse();
		settle(2);
		`CHK("irq track end", 1'b1, irq)
		apb(8'h00, 1'b0, 8'h04, 8'hFD);
		`CHK("bytes left", 0, sq.size())
		@(posedge clk);
		clr <= 1'b1;
		apb(8'h00, 1'b0, 8'h80, 8'h81);
		`CHK("head cleared", 1'b0, hl)
		@(posedge clk);
		clr <= 1'b0;
		ce  <= 1'b0;
		cmd(8'h00);
		`CHK("frozen head", 1'b0, hl)
		@(posedge clk);
		ce <= 1'b1;
		apb(8'h00, 1'b0, 8'h00, 8'h01);
		end_sim();
	endtask
endmodule // testbench
